// file: src/msl_defines.vh
// Constants shared by the modem status light logic.
// Assumes a single 125 MHz clock; long times are given in their own unit.
`ifndef MSL_DEFINES_VH
`define MSL_DEFINES_VH

// Clock rate in hertz
`define MSL_CLK_HZ          64'd125_000_000
// Value of the mode input that selects dedicated-line use
`define MSL_MODE_DEDICATED  1'b1
// Time without synchronisation before a retry, in seconds
`define MSL_SYNC_TIMEOUT_S  64'd60
// Time the online light stays dark between attempts, in milliseconds
`define MSL_BLANK_MS        64'd250
// Time a data light stays lit after line activity, in milliseconds
`define MSL_FLASH_MS        64'd20
// Cycle counts of the times above at the clock rate, sized to their counters
`define MSL_SYNC_TIMEOUT_CYC 36'h1_BF08_EB00
`define MSL_BLANK_CYC        36'h0_01DC_D650
`define MSL_FLASH_CYC        24'h26_25A0
// Width of the timeout counter, wide enough for sixty seconds
`define MSL_TIMER_W         36
// Width of the flash counter
`define MSL_FLASH_W         24

`endif

// file: src/msl_flash.v
// Activity stretcher for one serial data line driving one indicator.
// Assumes the line idles high (mark) and is synchronous to clk_in.
`default_nettype none

module msl_flash #(
  parameter integer CNT_W    = 24,
  parameter [CNT_W-1:0] HOLD_CYC = 24'h26_25A0
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_b_in,
  // Serial line observed
  input  wire             line_in,
  // Indicator drive
  output reg              led_out
);

  reg  [CNT_W-1:0] hold_r;   // Remaining lit time
  reg  [CNT_W-1:0] hold_nxt; // Next lit time

  // Reload on every space bit, else count down to zero
  always @* begin
    if (!line_in) begin
      hold_nxt = HOLD_CYC;
    end else if (hold_r != {CNT_W{1'b0}}) begin
      hold_nxt = hold_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      hold_nxt = hold_r;
    end
  end

  // Counter and light register; light stays lit until the count runs out
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      hold_r  <= {CNT_W{1'b0}};
      led_out <= 1'b0;
    end else begin
      hold_r  <= hold_nxt;
      led_out <= (hold_nxt != {CNT_W{1'b0}});
    end
  end

endmodule

`default_nettype wire

// file: src/msl_led_top.v
// Front-panel status light logic of an analog modem, six lights.
// Assumes all inputs synchronous to clk_in; event inputs are one-cycle pulses
// from the modem core; the mode input is static after reset.
//
// Notes on behaviour
// - Incoming call: online lights once terminal ready
// - Incoming call ends like outgoing call
// - Dial-up: ring light while call signalled
// - Dial-up: carrier light off at synchronisation
// - Dial-up: carrier light back on at end
// - Transmit light flashes with terminal data
// - Receive light flashes with data to terminal
// - Dedicated: ready light mirrors terminal ready
// - Dedicated: terminal ready has no other effect
// - Dedicated: sync after power, online lit
// - Dedicated: sixty-second timeout blanks, then retries
// - Dedicated: carrier light on after disruption
// - Dedicated: fifth light unused
// - Dial-up: lights four, five online/ring only
// - Outgoing call: online on dial accept
`include "msl_defines.vh"
`default_nettype none

module msl_led_top #(
  parameter [`MSL_TIMER_W-1:0] SYNC_TIMEOUT_CYC = `MSL_SYNC_TIMEOUT_CYC,
  parameter [`MSL_TIMER_W-1:0] BLANK_CYC        = `MSL_BLANK_CYC,
  parameter [`MSL_FLASH_W-1:0] FLASH_CYC        = `MSL_FLASH_CYC
) (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_b_in,
  // Operating mode and health
  input  wire mode_dedicated_in,
  input  wire power_ok_in,
  // Terminal-side serial lines
  input  wire dte_txd_in,
  input  wire dte_rxd_in,
  input  wire dte_dtr_in,
  // Modem core events
  input  wire ring_active_in,
  input  wire dial_accept_in,
  input  wire sync_done_in,
  input  wire call_end_in,
  input  wire disrupt_in,
  // Indicator drives
  output wire led_txd_out,
  output wire led_rxd_out,
  output reg  led_dtr_out,
  output reg  online_indicator_out,
  output reg  led_ring_out,
  output reg  led_dcd_out,
  // Request to the modem core to start a new sync attempt
  output reg  resync_start_out
);

  // Call and line states
  localparam [3:0] ST_IDLE  = 4'h0; // Dial-up, no call
  localparam [3:0] ST_DIAL  = 4'h1; // Dial-up, outgoing call setup
  localparam [3:0] ST_RING  = 4'h2; // Dial-up, incoming call signalled
  localparam [3:0] ST_ANSW  = 4'h3; // Dial-up, incoming call accepted
  localparam [3:0] ST_CONN  = 4'h4; // Dial-up, modems synchronised
  localparam [3:0] ST_WAIT  = 4'h5; // Dedicated, waiting for power
  localparam [3:0] ST_SYNC  = 4'h6; // Dedicated, sync attempt running
  localparam [3:0] ST_LOCK  = 4'h7; // Dedicated, synchronised
  localparam [3:0] ST_BLANK = 4'h8; // Dedicated, pause between attempts

  reg  [3:0]              state_r;   // Current state
  reg  [3:0]              state_nxt; // Next state
  reg  [`MSL_TIMER_W-1:0] timer_r;   // Cycles spent in timed state
  reg  [`MSL_TIMER_W-1:0] timer_nxt; // Next timer value
  reg                     resync_nxt; // Restart pulse next value
  wire                    ded_mode;  // Dedicated-line behaviour chosen
  wire                    call_stop; // Any end of a dial-up call
  wire                    sync_late; // Sync attempt ran out of time
  wire                    blank_done; // Dark pause is over

  assign ded_mode   = (mode_dedicated_in == `MSL_MODE_DEDICATED);
  assign call_stop  = call_end_in | disrupt_in;
  assign sync_late  = (timer_r >= SYNC_TIMEOUT_CYC - {{(`MSL_TIMER_W-1){1'b0}}, 1'b1});
  assign blank_done = (timer_r >= BLANK_CYC - {{(`MSL_TIMER_W-1){1'b0}}, 1'b1});

  // Transmit light follows data arriving from the terminal
  msl_flash #(
    .CNT_W    (`MSL_FLASH_W),
    .HOLD_CYC (FLASH_CYC)
  ) u_flash_tx (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .line_in  (dte_txd_in),
    .led_out  (led_txd_out)
  );

  // Receive light follows data sent to the terminal, any phase
  msl_flash #(
    .CNT_W    (`MSL_FLASH_W),
    .HOLD_CYC (FLASH_CYC)
  ) u_flash_rx (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .line_in  (dte_rxd_in),
    .led_out  (led_rxd_out)
  );

  // Next-state logic for both behaviour sets
  always @* begin
    state_nxt  = state_r;
    resync_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // Mode is static, so leave dial-up set at once if needed
        if (ded_mode) begin
          state_nxt = ST_WAIT;
        end else if (dial_accept_in && !call_stop) begin
          // A dial accept cancelled in the same cycle leaves the line idle unless ring is active
          state_nxt = ST_DIAL;
        end else if (ring_active_in) begin
          state_nxt = ST_RING;
        end
      end
      ST_DIAL: begin
        // Outgoing setup: connect or give up
        if (call_stop) begin
          state_nxt = ST_IDLE;
        end else if (sync_done_in) begin
          state_nxt = ST_CONN;
        end
      end
      ST_RING: begin
        // Incoming call: an end event wins, else terminal ready accepts it
        if (call_stop) begin
          state_nxt = ST_IDLE;
        end else if (dte_dtr_in) begin
          state_nxt = ST_ANSW;
        end else if (!ring_active_in) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ANSW: begin
        // Accepted call ends on the outgoing-call events
        if (call_stop) begin
          state_nxt = ST_IDLE;
        end else if (sync_done_in) begin
          state_nxt = ST_CONN;
        end
      end
      ST_CONN: begin
        // Normal end or disruption drops the link
        if (call_stop) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Start syncing once the modem is healthy
        if (power_ok_in) begin
          state_nxt  = ST_SYNC;
          resync_nxt = 1'b1;
        end
      end
      ST_SYNC: begin
        // Attempt running; terminal ready is ignored here
        if (sync_done_in) begin
          state_nxt = ST_LOCK;
        end else if (sync_late) begin
          state_nxt = ST_BLANK;
        end
      end
      ST_LOCK: begin
        // Disruption of a synchronised line starts a new attempt
        if (disrupt_in) begin
          state_nxt  = ST_SYNC;
          resync_nxt = 1'b1;
        end
      end
      ST_BLANK: begin
        // Short dark pause, then retry
        if (blank_done) begin
          state_nxt  = ST_SYNC;
          resync_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Timer counts cycles in the current timed state, restarts on change
  always @* begin
    if (state_nxt != state_r) begin
      timer_nxt = {`MSL_TIMER_W{1'b0}};
    end else if ((state_r == ST_SYNC) || (state_r == ST_BLANK)) begin
      timer_nxt = timer_r + {{(`MSL_TIMER_W-1){1'b0}}, 1'b1};
    end else begin
      timer_nxt = {`MSL_TIMER_W{1'b0}};
    end
  end

  // State, timer, restart pulse and the four non-data light registers
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r              <= ST_IDLE;
      timer_r              <= {`MSL_TIMER_W{1'b0}};
      led_dtr_out          <= 1'b0;
      online_indicator_out <= 1'b0;
      led_ring_out         <= 1'b0;
      led_dcd_out          <= 1'b0;
      resync_start_out     <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      timer_r          <= timer_nxt;
      resync_start_out <= resync_nxt;
      // Ready light shows the terminal line level
      led_dtr_out      <= dte_dtr_in;
      // Online light: call in progress or dedicated attempt or lock
      online_indicator_out <= (state_nxt == ST_DIAL) || (state_nxt == ST_ANSW) ||
                              (state_nxt == ST_CONN) || (state_nxt == ST_SYNC) ||
                              (state_nxt == ST_LOCK);
      // Ring light only in dial-up, never in dedicated use
      led_ring_out     <= !ded_mode && ring_active_in;
      // Carrier light: health shown, dark while synchronised
      led_dcd_out      <= power_ok_in && (state_nxt != ST_CONN) &&
                          (state_nxt != ST_LOCK);
    end
  end

endmodule

`default_nettype wire

// file: tb/msl_term_model.sv
// Terminal model: sends one serial frame on the transmit line per request.
// Assumes one bit per clock, line idles high (mark) between frames.
`default_nettype none
module msl_term_model (
  // Clock and frame request
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [7:0] byte_in,
  // Serial data to the modem
  output var  logic       txd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh_r = 10'h3ff;  // Stop, data, start bits
  // Load a frame on request, else shift in idle marks
  always @(posedge clk_in) begin
    if (go_in) sh_r <= {1'b1, byte_in, 1'b0};
    else sh_r <= {1'b1, sh_r[9:1]};
  end
  assign txd_out = sh_r[0];
endmodule
`default_nettype wire

// file: tb/msl_led_top_properties.sv
// Checker of light timing against mode, events and terminal lines.
// Assumes one clock domain; bound to the top module by the testbench.
`default_nettype none
module msl_led_props #(
  parameter int BLANK_CYC = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Mode, health and terminal ready
  input wire logic mode_dedicated_in,
  input wire logic power_ok_in,
  input wire logic dte_dtr_in,
  // Modem core events
  input wire logic ring_active_in,
  input wire logic dial_accept_in,
  input wire logic sync_done_in,
  input wire logic call_end_in,
  input wire logic disrupt_in,
  // Lights and restart request
  input wire logic led_dtr_out,
  input wire logic online_indicator_out,
  input wire logic led_ring_out,
  input wire logic led_dcd_out,
  input wire logic resync_start_out
);
  localparam int BL1 = BLANK_CYC - 1;  // Last dark cycle after the fall
  wire dm = !mode_dedicated_in;         // Dial-up selected
  wire en = call_end_in || disrupt_in;  // Any call end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_dtr_mirror: assert property ($past(rst_b_in) |-> led_dtr_out == $past(dte_dtr_in))
    else $error("ready light not following terminal ready");
  a_ring_follow: assert property (dm && $past(rst_b_in) |-> led_ring_out == $past(ring_active_in))
    else $error("ring light wrong in dial-up");
  a_ring_unused: assert property (mode_dedicated_in |-> !led_ring_out)
    else $error("fifth light lit in dedicated mode");
  a_dcd_power: assert property (!power_ok_in |=> !led_dcd_out)
    else $error("carrier light lit without power");
  a_dial_online: assert property (dm && dial_accept_in && !online_indicator_out && !led_ring_out
    && !ring_active_in && !en |=> online_indicator_out)
    else $error("dial accept did not light online");
  a_end_clears: assert property (dm && en |=> !online_indicator_out)
    else $error("online still lit after call end");
  a_sync_dcd: assert property (dm && online_indicator_out && sync_done_in && !en |=> !led_dcd_out)
    else $error("carrier light on after sync");
  a_end_dcd: assert property (dm && en |=> led_dcd_out == $past(power_ok_in))
    else $error("carrier light not back after call end");
  a_resync_one: assert property (resync_start_out |=> !resync_start_out)
    else $error("resync pulse longer than one cycle");
  a_ded_online: assert property (mode_dedicated_in && $rose(resync_start_out) |-> online_indicator_out)
    else $error("sync attempt without online light");
  a_blank_len: assert property (mode_dedicated_in && $fell(online_indicator_out)
    |-> ##BL1 !online_indicator_out ##1 (online_indicator_out && resync_start_out))
    else $error("online blank length wrong");
  a_ded_abort: assert property (mode_dedicated_in && disrupt_in && !led_dcd_out && power_ok_in
    && $past(power_ok_in) |=> led_dcd_out && resync_start_out)
    else $error("disruption did not relight carrier");
  c_dial: cover property (dm && dial_accept_in ##1 online_indicator_out);
  c_ring: cover property (dm && led_ring_out);
  c_blank: cover property (mode_dedicated_in && $fell(online_indicator_out));
endmodule
`default_nettype wire

// file: tb/msl_led_top_tb.sv
// Testbench of the status lights in both modes with shortened counts.
// Assumes the terminal model drives transmit data; the bench drives the rest.
`default_nettype none
module msl_led_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_b_in = 0, mode = 0, pwr = 1, rxd = 1, dtr = 0, ring = 0, go = 0;
  logic [3:0] ev = 0;      // Disrupt, end, sync, dial pulses
  logic [7:0] tx_byte = 0; // Frame sent by the terminal
  wire        txd;         // Transmit line from the terminal
  wire  [6:0] o;           // Resync, dcd, ring, online, dtr, rxd, txd
  logic [13:0] q[$];       // Mask and expected lights
  int err_count = 0, total_checks = 0, cyc = 0, n;
  event chk;
  localparam logic [6:0] TX = 7'h01, RX = 7'h02, DT = 7'h04, ON = 7'h08, RG = 7'h10, DC = 7'h20, RS = 7'h40;
  initial forever #4 clk_in = ~clk_in;
  msl_term_model u_term (.clk_in(clk_in), .go_in(go), .byte_in(tx_byte), .txd_out(txd));
  msl_led_top #(.SYNC_TIMEOUT_CYC(36'hc8), .BLANK_CYC(36'h14), .FLASH_CYC(24'h8)) uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .mode_dedicated_in(mode), .power_ok_in(pwr),
    .dte_txd_in(txd), .dte_rxd_in(rxd), .dte_dtr_in(dtr), .ring_active_in(ring),
    .dial_accept_in(ev[0]), .sync_done_in(ev[1]), .call_end_in(ev[2]), .disrupt_in(ev[3]),
    .led_txd_out(o[0]), .led_rxd_out(o[1]), .led_dtr_out(o[2]), .online_indicator_out(o[3]),
    .led_ring_out(o[4]), .led_dcd_out(o[5]), .resync_start_out(o[6]));
  task automatic step(input int k); repeat (k) @(negedge clk_in); endtask
  // One cycle of event pulses; a burst ends with an all-zero call
  task automatic pulse(input logic [3:0] m); ev = m; step(1); endtask
  task automatic ex(input logic [6:0] m, v); q.push_back({m, v}); -> chk; endtask
  task automatic cmp(input logic [6:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic md); rst_b_in = 0; mode = md; step(20); rst_b_in = 1; step(3); endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor: oldest note against the lights as they stand now
  always @(chk) while (q.size() > 0) begin
    cmp(o & q[0][13:7], q[0][6:0]);
    void'(q.pop_front());
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hac8b));
    do_reset(0);
    ex(DC | ON, DC);
    pulse(4'h2); ex(DC | ON, DC);
    pulse(4'h1); ex(ON | DC, ON | DC);
    pulse(4'h2); ex(ON | DC, ON);
    pulse(4'h4); ex(ON | DC, DC);
    pulse(4'h1); pulse(4'h2); pulse(4'h8); ex(ON | DC, DC);
    pulse(4'h0);
    $display("outgoing call done");
    ring = 1; step(1); ex(RG | ON, RG);
    dtr = 1; step(1); ex(ON | DT, ON | DT);
    ring = 0; pulse(4'h2); ex(DC | RG, 0);
    pulse(4'h8); ex(ON | DC, DC);
    pulse(4'h0);
    dtr = 0; pwr = 0; step(2); ex(DC | DT, 0);
    pwr = 1;
    $display("incoming call done");
    tx_byte = 8'($urandom());
    n = 1 + $urandom() % 4;
    go = 1; rxd = 0; step(1); go = 0; step(n); rxd = 1;
    ex(TX | RX, TX | RX);
    step(20); ex(TX | RX, 0);
    $display("data lights done");
    do_reset(1);
    ex(ON | DC | RG, ON | DC);
    dtr = 1; ring = 1; step(1); ex(DT | RG | ON, DT | ON);
    dtr = 0; ring = 0;
    n = 0;
    while (o[3] === 1'b1 && n < 300) begin step(1); n++; end
    ex(ON, 0); step(19); ex(ON, 0); step(1); ex(ON | RS, ON | RS);
    pulse(4'h2); ex(ON | DC, ON);
    pulse(4'h8); ex(DC | RS, DC | RS);
    pulse(4'h0);
    $display("dedicated line done");
    step(1);
    report_and_stop();
  end
endmodule
bind msl_led_top msl_led_props #(.BLANK_CYC(20)) u_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .mode_dedicated_in(mode_dedicated_in),
  .power_ok_in(power_ok_in), .dte_dtr_in(dte_dtr_in), .ring_active_in(ring_active_in),
  .dial_accept_in(dial_accept_in), .sync_done_in(sync_done_in), .call_end_in(call_end_in),
  .disrupt_in(disrupt_in), .led_dtr_out(led_dtr_out), .online_indicator_out(online_indicator_out),
  .led_ring_out(led_ring_out), .led_dcd_out(led_dcd_out), .resync_start_out(resync_start_out));
`default_nettype wire
